// File: pkg/hall_switch_defines.vh
// Constants for the peak-tracking Hall switch logic.
// Assumes a 100 MHz core clock; included by the design file only.
`ifndef HALL_SWITCH_DEFINES_VH
`define HALL_SWITCH_DEFINES_VH

`define SAMPLE_WIDTH 10
`define HYST_WIDTH 4
`define CLOCK_PERIOD_NS 10
// Comparison pace: one sample per 200 clocks, i.e. 500 kHz nominal
`define SAMPLE_PERIOD_CYCLES 200
`define FAULT_SHUTDOWN_MIN_US 100
`define FAULT_SHUTDOWN_MAX_US 200
// Least time rounds up; 100 us at 10 ns period
`define FAULT_SHUTDOWN_CYCLES ((`FAULT_SHUTDOWN_MIN_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SAMPLE_RESET_VALUE 10'h000
// Valley search starts at full scale so the first sample seeds the minimum
`define EXTREME_RESET_VALUE 10'h3ff

`endif

// File: design/hall_peak_tracking_switch.v
// Peak/valley tracking switch logic of a Hall gear-tooth sensor.
// Assumes a converter delivering field_sample on each sample_request and an analog
// short-circuit comparator; pin inputs are asynchronous to clock.
`include "hall_switch_defines.vh"
`default_nettype none

module hall_peak_tracking_switch #(
    parameter SAMPLE_WIDTH = `SAMPLE_WIDTH,
    parameter HYST_WIDTH = `HYST_WIDTH,
    parameter SAMPLE_PERIOD = `SAMPLE_PERIOD_CYCLES,
    parameter FAULT_CYCLES = `FAULT_SHUTDOWN_CYCLES
) (
    input wire clock,
    input wire resetn,
    input wire [SAMPLE_WIDTH-1:0] field_sample,
    input wire [HYST_WIDTH-1:0] switch_hysteresis_amount,
    input wire short_detect,
    input wire north_bias,
    output wire sample_request,
    output wire output_switch_point,
    output wire out_drive_oe,
    output wire fault_active,
    output wire test_mode
);

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Three flops; a change counts once stages two and three agree
    reg [2:0] short_sync_reg;
    reg [2:0] north_sync_reg;
    reg short_reg;
    reg north_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            short_sync_reg <= 3'b000;
            north_sync_reg <= 3'b000;
            short_reg <= 1'b0;
            north_reg <= 1'b0;
        end else begin
            short_sync_reg <= {short_sync_reg[1:0], short_detect};
            north_sync_reg <= {north_sync_reg[1:0], north_bias};
            if (short_sync_reg[1] == short_sync_reg[2]) begin
                short_reg <= short_sync_reg[2];
            end
            if (north_sync_reg[1] == north_sync_reg[2]) begin
                north_reg <= north_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Sample pacing
    // ------------------------------------------------------------
    reg [15:0] pace_reg;
    wire pace_tick = (pace_reg == SAMPLE_PERIOD[15:0] - 16'h0001);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pace_reg <= 16'h0000;
        end else if (pace_tick) begin
            pace_reg <= 16'h0000;
        end else begin
            pace_reg <= pace_reg + 16'h0001;
        end
    end

    assign sample_request = pace_tick;

    // ------------------------------------------------------------
    // Peak and valley tracking
    // ------------------------------------------------------------
    function [SAMPLE_WIDTH:0] widen;
        input [SAMPLE_WIDTH-1:0] value;
        begin
            widen = {1'b0, value};
        end
    endfunction

    localparam ST_ARM = 2'b00;
    localparam ST_RISE = 2'b01;
    localparam ST_FALL = 2'b10;

    reg [1:0] state_reg;
    reg [SAMPLE_WIDTH-1:0] hold_reg;
    reg [SAMPLE_WIDTH-1:0] extreme_reg;
    reg drive_reg;
    reg [SAMPLE_WIDTH-1:0] sample_reg;

    wire [SAMPLE_WIDTH:0] hyst_w;
    assign hyst_w = {{(SAMPLE_WIDTH+1-HYST_WIDTH){1'b0}}, switch_hysteresis_amount};
    wire rising = sample_reg > hold_reg;
    wire fell_from_max = widen(sample_reg) + hyst_w <= widen(extreme_reg);
    wire rose_from_min = widen(sample_reg) >= widen(extreme_reg) + hyst_w;

    reg sample_ready_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sample_reg <= `SAMPLE_RESET_VALUE;
            sample_ready_reg <= 1'b0;
        end else begin
            sample_ready_reg <= pace_tick;
            if (pace_tick) begin
                sample_reg <= field_sample;
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_ARM;
            hold_reg <= `SAMPLE_RESET_VALUE;
            extreme_reg <= `EXTREME_RESET_VALUE;
            drive_reg <= 1'b0;
        end else if (north_reg) begin
            state_reg <= ST_ARM;
            extreme_reg <= `EXTREME_RESET_VALUE;
            drive_reg <= 1'b0;
        end else if (sample_ready_reg) begin
            hold_reg <= sample_reg;
            case (state_reg)
                ST_ARM: begin
                    // Track down to the first valley without touching the driver;
                    // full-scale start means no rise can count before a sample
                    if (sample_reg < extreme_reg) begin
                        extreme_reg <= sample_reg;
                    end else if (rose_from_min) begin
                        state_reg <= ST_RISE;
                        extreme_reg <= sample_reg;
                    end
                end
                ST_RISE: begin
                    if (rising && sample_reg > extreme_reg) begin
                        extreme_reg <= sample_reg;
                    end else if (fell_from_max) begin
                        drive_reg <= 1'b1;
                        state_reg <= ST_FALL;
                        extreme_reg <= sample_reg;
                    end
                end
                ST_FALL: begin
                    if (!rising && sample_reg < extreme_reg) begin
                        extreme_reg <= sample_reg;
                    end else if (rose_from_min) begin
                        drive_reg <= 1'b0;
                        state_reg <= ST_RISE;
                        extreme_reg <= sample_reg;
                    end
                end
                default: begin
                    state_reg <= ST_ARM;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Short-circuit shutdown timer
    // ------------------------------------------------------------
    reg [15:0] fault_cnt_reg;
    reg fault_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_cnt_reg <= 16'h0000;
            fault_reg <= 1'b0;
        end else if (fault_reg) begin
            // Retry only after the full interval, even if the short has gone
            if (fault_cnt_reg == FAULT_CYCLES[15:0] - 16'h0001) begin
                fault_reg <= 1'b0;
                fault_cnt_reg <= 16'h0000;
            end else begin
                fault_cnt_reg <= fault_cnt_reg + 16'h0001;
            end
        end else if (short_reg && drive_reg) begin
            fault_reg <= 1'b1;
        end
    end

    reg test_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_reg <= 1'b0;
        end else begin
            test_reg <= north_reg;
        end
    end

    assign out_drive_oe = drive_reg & ~fault_reg;
    assign output_switch_point = drive_reg;
    assign fault_active = fault_reg;
    assign test_mode = test_reg;

endmodule // hall_peak_tracking_switch

`default_nettype wire

// File: verif/pullup_line_reader.sv
// Controller input reading the open-collector switch output.
// Assumes an external pull-up: the line is high unless the driver pulls it.
`default_nettype none
module pullup_line_reader (
    input wire logic out_drive_oe,
    output logic line_level
);
    timeunit 1ns;
    timeprecision 1ns;
    assign line_level = out_drive_oe ? 1'b0 : 1'b1;
endmodule // pullup_line_reader
`default_nettype wire

// File: verif/hall_peak_tracking_switch_assertions.sv
// Port checker for the peak-tracking Hall switch.
// Assumes one clock domain; bound to the design top below.
`default_nettype none
module hall_switch_checker #(parameter int FAULT_CYCLES = 10000) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic north_bias,
    input wire logic sample_request,
    input wire logic output_switch_point,
    input wire logic out_drive_oe,
    input wire logic fault_active,
    input wire logic test_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    int flen_reg;
    always_ff @(posedge clock) flen_reg <= fault_active ? flen_reg + 1 : 0;
    chk_oe_cause: assert property (
        out_drive_oe |-> output_switch_point && !fault_active) else $error("oe");
    chk_oe_rise: assert property (
        $rose(out_drive_oe) |-> $past(sample_request, 2) || $fell(fault_active)) else $error("oe rise");
    chk_switch_paced: assert property (
        $changed(output_switch_point) |-> $past(sample_request, 2) || test_mode) else $error("pace");
    chk_fault_len: assert property (
        $fell(fault_active) |-> flen_reg == FAULT_CYCLES) else $error("fault length");
    chk_fault_cause: assert property (
        $rose(fault_active) |-> !out_drive_oe && $past(output_switch_point)) else $error("fault");
    chk_req_pulse: assert property (
        sample_request |=> !sample_request) else $error("request");
    chk_reset_quiet: assert property (
        $rose(resetn) |-> !out_drive_oe && !output_switch_point) else $error("reset");
    chk_test_off: assert property (
        test_mode |=> !out_drive_oe) else $error("test drive");
    chk_test_entry: assert property (
        $rose(north_bias) |-> ##[1:8] test_mode) else $error("test entry");
    cover property ($rose(output_switch_point));
    cover property ($fell(fault_active));
    cover property ($rose(test_mode));
endmodule // hall_switch_checker
bind hall_peak_tracking_switch hall_switch_checker #(.FAULT_CYCLES(FAULT_CYCLES)) chk (
    .clock, .resetn, .north_bias, .sample_request, .output_switch_point, .out_drive_oe,
    .fault_active, .test_mode);
`default_nettype wire

// File: verif/hall_peak_tracking_switch_tb.sv
// Bench: random field wave, short fault and test entry for the Hall switch.
// Assumes shortened counts by parameter and a pull-up line model.
`default_nettype none
module hall_peak_tracking_switch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int H = 3;
    logic clock = 0, resetn = 0, short_detect = 0, north_bias = 0, run = 0, hold = 0, last = 0;
    logic [9:0] field_sample = 10'h200, e, exp_q[$];
    logic [3:0] switch_hysteresis_amount = 4'h3;
    logic [7:0] lfsr = 8'h11;
    bit take, seen, mon = 1;
    int failures, check_count, cycles, st, mx, n, k, mn = 1023, v = 512;
    wire sample_request, output_switch_point, out_drive_oe, fault_active, test_mode, line_level;
    hall_peak_tracking_switch #(.SAMPLE_PERIOD(4), .FAULT_CYCLES(20)) DUT (.clock, .resetn,
        .field_sample, .switch_hysteresis_amount, .short_detect, .north_bias, .sample_request,
        .output_switch_point, .out_drive_oe, .fault_active, .test_mode);
    pullup_line_reader line_model (.out_drive_oe, .line_level);
    initial forever #5 clock = ~clock;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [9:0] seen_v, exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp_v, seen_v);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Model steps on every capture, so held fields repeat harmlessly
    always @(negedge clock) begin
        if (mon && output_switch_point !== last) begin
            e = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
            check("switch", 10'(output_switch_point), e);
        end
        last = output_switch_point;
        if (resetn && sample_request) begin
            if (v < mn && st != 1) begin
                mn = v;
                seen = 1;
            end else if (st == 1 && v > mx) mx = v;
            else if (st != 1 && seen && v >= mn + H) begin
                if (st == 2) exp_q.push_back(10'h000);
                st = 1;
                mx = v;
            end else if (st == 1 && v + H <= mx) begin
                st = 2;
                mn = v;
                exp_q.push_back(10'h001);
            end
            take = run && !(hold && st == 2);
        end else if (!resetn) begin
            st = 0;
            mn = 1023;
            seen = 0;
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (take) begin
            lfsr = lfsr_next(lfsr);
            v += n[3] ? int'(lfsr[3:0]) : -int'(lfsr[3:0]);
            v = v < 20 ? 20 : v > 1000 ? 1000 : v;
            field_sample <= 10'(v);
            n++;
            take = 0;
        end
        if (cycles == 8000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1;
        run <= 1;
        @(negedge clock);
        check("line at reset", 10'(line_level), 10'h001);
        repeat (256) @(posedge clock);
        hold = 1;
        for (k = 0; k < 2000 && output_switch_point !== 1'b1; k++) @(negedge clock);
        @(posedge clock);
        short_detect <= 1;
        for (k = 0; k < 20 && fault_active !== 1'b1; k++) @(negedge clock);
        check("line in fault", 10'(line_level), 10'h001);
        @(posedge clock);
        short_detect <= 0;
        @(negedge clock);
        for (k = 2; k < 99 && fault_active === 1'b1; k++) @(negedge clock);
        check("fault cycles", 10'(k), 10'h015);
        // Mid-run reset with the driver on: the line must go high at once
        @(posedge clock);
        exp_q.push_back(10'h000);
        resetn <= 0;
        @(negedge clock);
        check("line in reset", 10'(line_level), 10'h001);
        repeat (3) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        hold = 0;
        repeat (256) @(posedge clock);
        hold = 1;
        for (k = 0; k < 2000 && output_switch_point !== 1'b1; k++) @(negedge clock);
        run <= 0;
        repeat (16) @(posedge clock);
        mon = 0;
        north_bias <= 1;
        repeat (12) @(negedge clock);
        check("test mode", 10'(test_mode), 10'h001);
        check("line in test", 10'(line_level), 10'h001);
        check("pending", 10'(exp_q.size()), 10'h000);
        give_verdict();
    end
endmodule // hall_peak_tracking_switch_tb
`default_nettype wire
